// ---- rtl/csc_channel.sv ----
// Purpose: Clocked synchronous serial channel one with APB registers
// Assumes: APB slave, zero wait states; data shifts LSB first
// Notes:   Output changes on serial clock fall, input sampled on rise
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Clock select picks divider or external input
// - Data registers hold transmit then receive word
// - Eight-bit mode leaves upper register untouched
// - Sixteen-bit mode: upper register is high byte
// - Sixteen-bit mode: lower register is low byte
// - Eight-bit mode shifts through lower register
module csc_channel
  import csc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             busy
);
  logic        rst_meta_r;     // Reset release stage one
  logic        rst_sync_b;     // Reset release stage two
  logic [7:0]  mode_r;         // Serial mode control
  logic [7:0]  data_upper_r;   // Upper data register
  logic [7:0]  data_lower_r;   // Lower data register
  logic        level_r;        // Extended data bit for idle output
  csc_state_t  state_r;        // Sequencer state
  logic [4:0]  bits_r;         // Bits left in the word
  logic [2:0]  ext_sync_r;     // External clock sync plus history
  logic [1:0]  sin_sync_r;     // Serial input synchroniser
  logic        out_r;          // Registered serial output
  csc_pins_t   pins;           // Grouped pin drive
  logic        wr_en;          // APB write strobe
  logic        rd_en;          // APB read access
  logic        start_wr;       // Write to start register
  logic        ext_mode;       // External serial clock selected
  logic        wide;           // Sixteen-bit word length
  logic        cont_mode;      // Continuous clock output mode
  logic        div_fall;       // Internal clock fall strobe
  logic        div_rise;       // Internal clock rise strobe
  logic        div_sclk;       // Internal clock level
  logic        ext_fall;       // External clock falling edge
  logic        ext_rise;       // External clock rising edge
  logic        sh_fall;        // Shift-out moment
  logic        sh_rise;        // Sample moment
  logic        run_div;        // Divider enable
  logic [15:0] word;           // Word seen as one shifter

  // Reset is asserted at once and released through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // Mode field decode
  assign ext_mode  = (mode_r[CSC_CKS_LSB +: 4] == CSC_CKS_EXT);
  assign cont_mode = (mode_r[CSC_OPM_LSB +: 2] == 2'h0);
  assign wide      = mode_r[CSC_WIDE_BIT];

  // APB: zero wait states, every address answers without error
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !pwrite;
  assign start_wr = wr_en && (paddr == CSC_ADDR_START) && (state_r == CSC_IDLE);

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        CSC_ADDR_DATA_UPPER: prdata = {24'h00_0000, data_upper_r};
        CSC_ADDR_DATA_LOWER: prdata = {24'h00_0000, data_lower_r};
        CSC_ADDR_OUT_LEVEL:  prdata = {24'h00_0000, level_r, 7'h7f};
        CSC_ADDR_START:      prdata = {31'h0000_0000, state_r != CSC_IDLE};
        default:             prdata = 32'h0000_0000;
      endcase
    end
  end

  // Mode register; writes ignored mid-transfer so clocking stays stable
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mode_r <= CSC_MODE_RST;
    end else if (wr_en && paddr == CSC_ADDR_MODE && state_r != CSC_SHIFT) begin
      mode_r <= pwdata[7:0];
    end
  end

  // Idle level of the output pin
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      level_r <= CSC_LEVEL_RST[CSC_LEVEL_BIT];
    end else if (wr_en && paddr == CSC_ADDR_OUT_LEVEL) begin
      level_r <= pwdata[CSC_LEVEL_BIT];
    end
  end

  // Synchronise pin inputs; edge detect reads only the second stage on
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ext_sync_r <= 3'h7;
      sin_sync_r <= 2'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], serial_clock_pin_in};
      sin_sync_r <= {sin_sync_r[0], serial_in_pin};
    end
  end

  assign ext_fall = ext_sync_r[2] && !ext_sync_r[1];
  assign ext_rise = !ext_sync_r[2] && ext_sync_r[1];

  // Internal divider runs only when it drives the clock pin
  assign run_div = !ext_mode && (state_r != CSC_IDLE);

  csc_clkdiv u_div (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .run        (run_div),
    .cks        (mode_r[CSC_CKS_LSB +: 3]),
    .fall_stb   (div_fall),
    .rise_stb   (div_rise),
    .sclk       (div_sclk)
  );

  // Edge source follows the clock select
  assign sh_fall = ext_mode ? ext_fall : div_fall;
  assign sh_rise = ext_mode ? ext_rise : div_rise;

  // Upper register joins the shifter only in wide mode
  assign word = wide ? {data_upper_r, data_lower_r} : {8'h00, data_lower_r};

  // Sequencer: start write begins a word or continuous clocking
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= CSC_IDLE;
      bits_r  <= 5'h00;
    end else begin
      case (state_r)
        CSC_IDLE: begin
          if (start_wr && cont_mode) begin
            state_r <= CSC_CONT;
          end else if (start_wr) begin
            state_r <= CSC_SHIFT;
            bits_r  <= wide ? CSC_BITS_WIDE : CSC_BITS_NARROW;
          end
        end
        CSC_SHIFT: begin
          // Word ends at the sample edge of its last bit
          if (sh_rise) begin
            bits_r <= bits_r - 5'h01;
            if (bits_r == 5'h01) begin
              state_r <= CSC_IDLE;
            end
          end
        end
        CSC_CONT: begin
          // Continuous clock stops on a mode change away from it
          if (!cont_mode) begin
            state_r <= CSC_IDLE;
          end
        end
        default: state_r <= CSC_IDLE;
      endcase
    end
  end

  // Output bit updates on the falling edge; idle shows the extended bit
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_r <= 1'b1;
    end else if (state_r == CSC_SHIFT && sh_fall) begin
      out_r <= word[0];
    end else if (state_r == CSC_IDLE) begin
      out_r <= level_r;
    end
  end

  // Data registers: software load, shift right while receiving
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_lower_r <= 8'h00;
    end else if (state_r == CSC_SHIFT && sh_rise) begin
      data_lower_r <= wide ? {data_upper_r[0], data_lower_r[7:1]}
                           : {sin_sync_r[1], data_lower_r[7:1]};
    end else if (wr_en && paddr == CSC_ADDR_DATA_LOWER && state_r != CSC_SHIFT) begin
      data_lower_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_upper_r <= 8'h00;
    end else if (state_r == CSC_SHIFT && sh_rise && wide) begin
      data_upper_r <= {sin_sync_r[1], data_upper_r[7:1]};
    end else if (wr_en && paddr == CSC_ADDR_DATA_UPPER && state_r != CSC_SHIFT) begin
      data_upper_r <= pwdata[7:0];
    end
  end

  // Pin drive: clock pin output only for internal clock
  always_comb begin
    pins.clk_oe   = !ext_mode;
    pins.clk_out  = div_sclk;
    pins.data_out = out_r;
  end

  assign serial_clock_pin_out = pins.clk_out;
  assign serial_clock_pin_oe  = pins.clk_oe;
  assign serial_out_pin       = pins.data_out;
  assign busy                 = (state_r != CSC_IDLE);
endmodule

// ---- include/csc_pkg.sv ----
// Purpose: Shared constants and types for serial channel one
// Assumes: 8-bit registers, one per aligned APB word
// Notes:   Offsets are byte addresses (index times four)
package csc_pkg;
  // Register indices and byte addresses
  localparam logic [7:0]  CSC_IDX_DATA_UPPER = 8'hb1;
  localparam logic [7:0]  CSC_IDX_DATA_LOWER = 8'hb2;
  localparam logic [7:0]  CSC_IDX_MODE       = 8'hb0;
  localparam logic [7:0]  CSC_IDX_OUT_LEVEL  = 8'hb3;
  localparam logic [7:0]  CSC_IDX_START      = 8'hb4;
  localparam logic [11:0] CSC_ADDR_DATA_UPPER = {2'h0, CSC_IDX_DATA_UPPER, 2'h0};
  localparam logic [11:0] CSC_ADDR_DATA_LOWER = {2'h0, CSC_IDX_DATA_LOWER, 2'h0};
  localparam logic [11:0] CSC_ADDR_MODE       = {2'h0, CSC_IDX_MODE, 2'h0};
  localparam logic [11:0] CSC_ADDR_OUT_LEVEL  = {2'h0, CSC_IDX_OUT_LEVEL, 2'h0};
  localparam logic [11:0] CSC_ADDR_START      = {2'h0, CSC_IDX_START, 2'h0};
  // Mode and output level register fields and reset values
  localparam int          CSC_CKS_LSB   = 0;
  localparam int          CSC_OPM_LSB   = 4;
  localparam int          CSC_WIDE_BIT  = 6;
  localparam logic [7:0]  CSC_MODE_RST  = 8'h80;
  localparam logic [3:0]  CSC_CKS_EXT   = 4'hf;
  localparam logic [7:0]  CSC_LEVEL_RST = 8'h7f;
  localparam int          CSC_LEVEL_BIT = 7;
  // Status word: busy in bit 0
  localparam int          CSC_BUSY_BIT  = 0;
  // Bit counts per word length
  localparam logic [4:0]  CSC_BITS_NARROW = 5'h08;
  localparam logic [4:0]  CSC_BITS_WIDE   = 5'h10;
  // Half serial period minus one, in system clocks, indexed by clock select code
  localparam logic [7:0][9:0] CSC_HALF_M1 = {10'h000, 10'h001, 10'h003, 10'h007,
                                             10'h00f, 10'h01f, 10'h07f, 10'h1ff};
  // Transfer sequencer states
  typedef enum logic [2:0] {
    CSC_IDLE  = 3'h1,
    CSC_SHIFT = 3'h2,
    CSC_CONT  = 3'h4
  } csc_state_t;
  // Serial pin group
  typedef struct packed {
    logic clk_out;
    logic clk_oe;
    logic data_out;
  } csc_pins_t;
endpackage

// ---- rtl/csc_clkdiv.sv ----
// Purpose: Internal serial clock generator for channel one
// Assumes: Code select 0..7 picks divide 1024 down to 2
// Notes:   Emits a fall and a rise strobe per serial period
`timescale 1ns/1ps
module csc_clkdiv
  import csc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_sync_b,
  input  wire logic       run,
  input  wire logic [2:0] cks,
  output logic            fall_stb,
  output logic            rise_stb,
  output logic            sclk
);
  logic [9:0] cnt_r;   // Free divider, cleared while idle
  logic [9:0] half;    // Half-period count minus one
  logic       tick;    // End of a half period

  // Code 0 is slowest, code 7 fastest; first two steps are four-fold, the rest two-fold
  always_comb begin
    half = CSC_HALF_M1[cks];
  end

  assign tick = run && (cnt_r == half);

  // Half-period counter; idle holds it cleared so each frame starts alike
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_r <= 10'h000;
    end else if (!run || tick) begin
      cnt_r <= 10'h000;
    end else begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  // Serial clock idles high, toggles each half period
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sclk <= 1'b1;
    end else if (!run) begin
      sclk <= 1'b1;
    end else if (tick) begin
      sclk <= ~sclk;
    end
  end

  assign fall_stb = tick && sclk;
  assign rise_stb = tick && !sclk;
endmodule

// ---- testbench/csc_channel_checker.sv ----
// Purpose: Port checks for serial channel one
// Assumes: Mode and data writes are taken only while idle or in continuous mode
// Notes:   Shadow copies predict pin direction and word length
`timescale 1ns/1ps
module csc_channel_checker
  import csc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_out_pin,
  input wire logic        busy
);
  logic        wr;        // Write taken this edge
  logic        rd;        // Read in progress
  logic [7:0]  mode_r;    // Mode shadow
  logic [7:0]  up_r;      // Upper data shadow
  logic        up_ok_r;   // Shadow still valid
  logic        wr_bsy_r;  // Mode written mid-run: skip length check
  logic [15:0] cnt_r;     // Busy length
  logic [15:0] exp_len;   // Bits times serial period
  logic [15:0] div;       // Serial period in system clocks
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  // Divisor per clock select code
  always_comb begin
    case (mode_r[2:0])
      3'h0:    div = 16'h0400;
      3'h1:    div = 16'h0100;
      3'h2:    div = 16'h0040;
      3'h3:    div = 16'h0020;
      3'h4:    div = 16'h0010;
      3'h5:    div = 16'h0008;
      3'h6:    div = 16'h0004;
      default: div = 16'h0002;
    endcase
  end
  assign exp_len = (mode_r[6] ? 16'h0010 : 16'h0008) * div;
  // Shadows; continuous runs accept mode writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= CSC_MODE_RST;
      up_r <= 8'h00;
      up_ok_r <= 1'b0;
      wr_bsy_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else begin
      if (wr && paddr == CSC_ADDR_MODE && (!busy || mode_r[5:4] == 2'b00)) mode_r <= pwdata[7:0];
      if (wr && paddr == CSC_ADDR_DATA_UPPER && (!busy || mode_r[5:4] == 2'b00)) begin
        up_r <= pwdata[7:0];
        up_ok_r <= 1'b1;
      end else if (busy && mode_r[6]) up_ok_r <= 1'b0;
      wr_bsy_r <= busy && (wr_bsy_r || (wr && paddr == CSC_ADDR_MODE));
      cnt_r <= busy ? cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_OE_DIR: assert property (!$past(wr && paddr == CSC_ADDR_MODE) && !$past(wr, 2)
    |-> serial_clock_pin_oe == (mode_r[3:0] != CSC_CKS_EXT)) else $error("pin direction wrong");
  AST_IDLE_CLK: assert property (!busy [*3] |-> serial_clock_pin_out)
    else $error("serial clock not high while idle");
  AST_START: assert property (wr && paddr == CSC_ADDR_START && !busy |-> ##[1:2] busy)
    else $error("start did not raise busy");
  AST_MODE_WO: assert property (rd && paddr == CSC_ADDR_MODE |-> prdata == 32'h0)
    else $error("mode register readable");
  AST_UPPER_KEPT: assert property (rd && paddr == CSC_ADDR_DATA_UPPER && up_ok_r && !mode_r[6]
    |-> prdata[7:0] == up_r) else $error("upper data changed in narrow mode");
  AST_OUT_HOLD: assert property (busy && $past(busy) && serial_clock_pin_oe
    && serial_clock_pin_out && $past(serial_clock_pin_out)
    |-> $stable(serial_out_pin)) else $error("data moved on high");
  AST_WORD_LEN: assert property ($fell(busy) && mode_r[5:4] != 2'b00
    && !mode_r[3] && !wr_bsy_r |-> cnt_r + 16'h0002 >= exp_len && cnt_r <= exp_len + 16'h0002)
    else $error("word length wrong");
  AST_CONT_RUN: assert property (busy && mode_r[5:4] == 2'b00 && serial_clock_pin_oe
    && serial_clock_pin_out |-> ##[1:520] (!serial_clock_pin_out || !busy))
    else $error("continuous clock stalled");
  COV_WIDE: cover property ($fell(busy) && mode_r[6]);
  COV_EXT: cover property (busy && !serial_clock_pin_oe);
  COV_CONT: cover property (busy && mode_r[5:4] == 2'b00);
endmodule
bind csc_channel csc_channel_checker u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_out_pin(serial_out_pin), .busy(busy));

// ---- testbench/csc_peer.sv ----
// Purpose: Far-side serial peer for channel one
// Assumes: LSB first, drive on fall, sample on rise
// Notes:   External clock half period 40 ns, idles high
`timescale 1ns/1ps
module csc_peer (
  input  wire logic sclk,
  input  wire logic sdo,
  output logic      sdi,
  output logic      ext_clk
);
  logic [15:0] tx;   // Word to send
  logic [15:0] rx;   // Word received
  int          n;    // Bits in frame
  int          ti;   // Next bit out
  int          ri;   // Next bit in
  initial begin
    sdi = 1'b1;
    ext_clk = 1'b1;
    n = 0;
  end
  // Arm a frame
  task automatic load(input logic [15:0] t, input int bits);
    tx = t;
    n = bits;
    ti = 0;
    ri = 0;
    rx = 16'h0000;
  endtask
  // Clock for external mode, only within a frame
  task automatic run_clk(input int bits);
    // Offset keeps pin edges away from the system clock edge
    #2;
    repeat (bits) begin
      #40 ext_clk = 1'b0;
      #40 ext_clk = 1'b1;
    end
  endtask
  // Outside a frame the line toggles, never holds old data
  always @(negedge sclk) begin
    if (ti < n) begin
      sdi <= tx[ti];
      ti <= ti + 1;
    end else sdi <= ~sdi;
  end
  always @(posedge sclk) begin
    if (ri < n) begin
      rx[ri] <= sdo;
      ri <= ri + 1;
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: Register and link test of serial channel one
// Assumes: Zero-wait APB slave, peer on far side
// Notes:   Fast codes check transmit only (input sync delay)
`timescale 1ns/1ps
module tb_top
  import csc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        rd_err;                               // Error response of last access
  int          div_tab [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};  // Divisor per select code
  logic        pready, pslverr, sck_out, sck_oe, sdo, sdi, busy, ext_ck;
  wire logic   sclk_w = sck_oe ? sck_out : ext_ck;  // Pin level from whichever end drives
  int          miscompares = 0;
  int          check_count = 0;
  int          hp;
  always #4 clk = ~clk;
  csc_channel dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin_in(sclk_w), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
    .serial_in_pin(sdi), .serial_out_pin(sdo), .busy(busy));
  csc_peer peer (.sclk(sclk_w), .sdo(sdo), .sdi(sdi), .ext_clk(ext_ck));
  task results;
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer, read data left in rd
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin chk(32'h1, 32'h0); results; end
  endtask
  // Low phase length of the serial clock
  task half;
    hp = 0;
    while (sck_out !== 1'b0 && hp < 600) begin
      @(posedge clk);
      hp++;
    end
    if (hp >= 600) begin
      chk(32'h1, 32'h0);
      results;
    end
    hp = 0;
    while (sck_out === 1'b0 && hp < 600) begin
      @(posedge clk);
      hp++;
    end
    if (hp >= 600) begin
      chk(32'h1, 32'h0);
      results;
    end
  endtask
  // Set mode and data, start, wait for the word to end
  task xfer(input logic [7:0] m, input logic [15:0] dv, input logic [15:0] pv, input int nb);
    int k;
    apb(CSC_ADDR_MODE, 1'b1, {24'h0, m});
    apb(CSC_ADDR_DATA_LOWER, 1'b1, {24'h0, dv[7:0]});
    apb(CSC_ADDR_DATA_UPPER, 1'b1, {24'h0, dv[15:8]});
    // Arm the peer only once a stopped continuous clock has settled
    peer.load(pv, nb);
    apb(CSC_ADDR_START, 1'b1, 32'h0);
    if (m[3:0] == CSC_CKS_EXT) peer.run_clk(nb);
    else half;
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin @(posedge clk); k++; end
    if (k >= 20000) begin chk(32'h1, 32'h0); results; end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(CSC_ADDR_MODE, 1'b0, 32'h0); chk(rd, 32'h0);
    chk({31'h0, sck_oe}, 32'h1);
    apb(CSC_ADDR_OUT_LEVEL, 1'b1, 32'h0);
    apb(CSC_ADDR_OUT_LEVEL, 1'b0, 32'h0); chk(rd, 32'h7f);
    chk({31'h0, sdo}, 32'h0);
    apb(CSC_ADDR_OUT_LEVEL, 1'b1, 32'h80);
    apb(CSC_ADDR_OUT_LEVEL, 1'b0, 32'h0); chk(rd, 32'hff);
    chk({31'h0, sdo}, 32'h1);
    apb(12'h3fc, 1'b0, 32'h0); chk(rd, 32'h0);
    chk({31'h0, rd_err}, 32'h0);
    for (int c = 0; c < 8; c++) begin
      xfer({4'h1, 4'(c)}, {8'h00, 8'ha5 ^ 8'(c)}, 16'h0, 8);
      chk(hp, div_tab[c] / 2);
      chk({16'h0, peer.rx}, {24'h0, 8'ha5 ^ 8'(c)});
    end
    xfer(8'h15, 16'h3c96, 16'h005a, 8); chk({16'h0, peer.rx}, 32'h96);
    apb(CSC_ADDR_DATA_LOWER, 1'b0, 32'h0); chk(rd, 32'h5a);
    apb(CSC_ADDR_DATA_UPPER, 1'b0, 32'h0); chk(rd, 32'h3c);
    xfer(8'h55, 16'hc3e1, 16'h1b72, 16); chk({16'h0, peer.rx}, 32'hc3e1);
    apb(CSC_ADDR_DATA_UPPER, 1'b0, 32'h0); chk(rd, 32'h1b);
    apb(CSC_ADDR_DATA_LOWER, 1'b0, 32'h0); chk(rd, 32'h72);
    xfer(8'h1f, 16'h0069, 16'h00b4, 8); chk({31'h0, sck_oe}, 32'h0);
    chk({16'h0, peer.rx}, 32'h69);
    apb(CSC_ADDR_DATA_LOWER, 1'b0, 32'h0); chk(rd, 32'hb4);
    peer.load(16'h0, 0);
    apb(CSC_ADDR_MODE, 1'b1, 32'h05);
    apb(CSC_ADDR_START, 1'b1, 32'h0);
    half; chk(hp, 4);
    half; chk({31'h0, busy}, 32'h1);
    xfer(8'h15, 16'h0033, 16'h0, 8); chk({31'h0, busy}, 32'h0);
    chk({16'h0, peer.rx}, 32'h33);
    results;
  end
endmodule
